// ===== src/ues_defs.svh
// Constants for the uncorrectable error flag and suppress register pair
`ifndef UES_DEFS_SVH
`define UES_DEFS_SVH

// Configuration space byte offsets
`define UES_ADDR_W 12
`define UES_OFS_FLAGS 12'h104
`define UES_OFS_SUPPRESS 12'h108

// Field positions
`define UES_BIT_UNSUP_REQ 20
`define UES_BIT_E2E_CRC 19
`define UES_BIT_MALFORMED 18
`define UES_BIT_RX_OVERFLOW 17
`define UES_BIT_UNEXP_CPL 16
`define UES_BIT_COMPLETER_ABORT_FLAG 15
`define UES_BIT_COMPLETION_TIMEOUT_FLAG 14
`define UES_BIT_FC_PROTO 13
`define UES_BIT_POISONED 12
`define UES_BIT_LINK_PROTO 4

// Implemented bits and reset values
`define UES_IMPL_MASK 32'h001f_f010
`define UES_FLAGS_RST 32'h0000_0000
`define UES_SUPPRESS_RST 32'h0000_0000

`endif

// ===== src/ues_pkg.sv
// Types shared by the uncorrectable error register pair
`default_nettype none
package ues_pkg;

   // Register selected by a configuration access
   typedef enum logic [1:0] {
      UES_SEL_NONE = 2'b00,
      UES_SEL_FLAGS = 2'b01,
      UES_SEL_SUPPRESS = 2'b10
   } ues_sel_t;

   // State of one flag cell
   typedef struct packed {
      logic flag;
      logic suppress;
   } ues_cell_t;

   // State of the register pair core
   typedef struct packed {
      logic [1:0] sync_a;
      logic [1:0] sync_b;
      logic [1:0] sync_c;
      logic [1:0] rst_lvl;
      logic [31:0] rdata;
      logic rvalid;
      logic msg_fatal;
      logic msg_nonfatal;
      logic log_load;
      logic [31:0] log_vec;
      logic first_upd;
      logic [4:0] first_idx;
   } ues_core_t;

endpackage
`default_nettype wire

// ===== src/ues_flag_cell.sv
// One sticky error flag with its suppress bit
`timescale 1ns/100ps
`default_nettype none
module ues_flag_cell
   import ues_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic clear_in,
   input wire logic event_in,
   input wire logic w1c_in,
   input wire logic mask_we_in,
   input wire logic mask_wd_in,
   output logic flag_out,
   output logic suppress_out
);

   ues_cell_t s;
   ues_cell_t next_s;

   // Next flag and suppress values
   always_comb
   begin
      next_s = s;
      if (clear_in)
      begin
         next_s.flag = 1'b0;
         next_s.suppress = 1'b0;
      end
      else
      begin
         if (mask_we_in)
         begin
            next_s.suppress = mask_wd_in;
         end
         // Set beats clear so no error slips by unseen
         if (event_in && !s.suppress)
         begin
            next_s.flag = 1'b1;
         end
         else if (w1c_in)
         begin
            next_s.flag = 1'b0;
         end
      end
   end

   // Power-on reset clears both bits
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign flag_out = s.flag;
   assign suppress_out = s.suppress;

endmodule
`default_nettype wire

// ===== src/ues_regs.sv
// Uncorrectable error flag and suppress registers with error reporting
`timescale 1ns/100ps
`default_nettype none
`include "ues_defs.svh"
module ues_regs
   import ues_pkg::*;
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   // Reset pins, asynchronous to the core clock
   input wire logic link_reset_n_in,
   input wire logic global_reset_input_n_in,
   // Configuration access port
   input wire logic cfg_wr_in,
   input wire logic cfg_rd_in,
   input wire logic [11:0] cfg_addr_in,
   input wire logic [3:0] cfg_be_in,
   input wire logic [31:0] cfg_wdata_in,
   output logic [31:0] cfg_rdata_out,
   output logic cfg_rvalid_out,
   // Error events from the primary link layers, one-cycle pulses
   input wire logic unsupported_request_in,
   input wire logic end_to_end_crc_in,
   input wire logic malformed_packet_in,
   input wire logic receiver_overflow_in,
   input wire logic unexpected_completion_in,
   input wire logic completer_abort_in,
   input wire logic completion_timeout_in,
   input wire logic flow_control_protocol_in,
   input wire logic poisoned_packet_in,
   input wire logic link_protocol_in,
   // Severity register contents, owned elsewhere
   input wire logic [31:0] severity_in,
   // Reporting outputs
   output logic msg_fatal_out,
   output logic msg_nonfatal_out,
   output logic log_load_out,
   output logic [31:0] log_vec_out,
   output logic first_error_update_out,
   output logic [4:0] first_error_index_out,
   // Live register contents
   output logic [31:0] flags_out,
   output logic [31:0] suppress_out
);

   // Implemented bit pattern, shared by both registers
   localparam logic [31:0] IMPL = `UES_IMPL_MASK;
   // Dword addresses of the pair, sized to the decoded address bits
   localparam logic [9:0] FLAGS_DW = 10'(`UES_OFS_FLAGS >> 2);
   localparam logic [9:0] SUPPRESS_DW = 10'(`UES_OFS_SUPPRESS >> 2);

   ues_core_t s;
   ues_core_t next_s;

   logic clear_all;
   logic [31:0] ev_vec;
   logic [31:0] flags_vec;
   logic [31:0] suppress_vec;
   logic [31:0] w1c_vec;
   logic [31:0] mask_we_vec;
   logic [31:0] lane_vec;
   logic [31:0] unmasked;
   ues_sel_t sel;

   // Highest numbered bit set in a vector
   function automatic logic [4:0] ues_top_index(input logic [31:0] vec);
      logic [4:0] idx;
      idx = 5'h00;
      for (int k = 0; k < 32; k++)
      begin
         if (vec[k])
         begin
            idx = 5'(k);
         end
      end
      return idx;
   endfunction

   // Either reset pin, once filtered, wipes the register pair
   assign clear_all = |s.rst_lvl;

   // Event vector; only primary side events have a port at all
   always_comb
   begin
      ev_vec = 32'h0000_0000;
      ev_vec[`UES_BIT_UNSUP_REQ] = unsupported_request_in;
      ev_vec[`UES_BIT_E2E_CRC] = end_to_end_crc_in;
      ev_vec[`UES_BIT_MALFORMED] = malformed_packet_in;
      ev_vec[`UES_BIT_RX_OVERFLOW] = receiver_overflow_in;
      ev_vec[`UES_BIT_UNEXP_CPL] = unexpected_completion_in;
      ev_vec[`UES_BIT_COMPLETER_ABORT_FLAG] = completer_abort_in;
      ev_vec[`UES_BIT_COMPLETION_TIMEOUT_FLAG] = completion_timeout_in;
      ev_vec[`UES_BIT_FC_PROTO] = flow_control_protocol_in;
      ev_vec[`UES_BIT_POISONED] = poisoned_packet_in;
      ev_vec[`UES_BIT_LINK_PROTO] = link_protocol_in;
   end

   // Register decode on the dword address, low two bits ignored
   always_comb
   begin
      case (cfg_addr_in[11:2])
         FLAGS_DW:
         begin
            sel = UES_SEL_FLAGS;
         end
         SUPPRESS_DW:
         begin
            sel = UES_SEL_SUPPRESS;
         end
         default:
         begin
            sel = UES_SEL_NONE;
         end
      endcase
   end

   // Byte enables widened to one bit per data bit
   always_comb
   begin
      for (int b = 0; b < 32; b++)
      begin
         lane_vec[b] = cfg_be_in[b / 8];
      end
   end

   // Write-one-clear strobes for flags, plain write for suppress
   assign w1c_vec = (cfg_wr_in && sel == UES_SEL_FLAGS) ?
                    (cfg_wdata_in & lane_vec & IMPL) : 32'h0000_0000;
   assign mask_we_vec = (cfg_wr_in && sel == UES_SEL_SUPPRESS) ?
                        (lane_vec & IMPL) : 32'h0000_0000;

   // Per-bit cells; reserved positions hold no storage at all
   genvar i;
   generate
      for (i = 0; i < 32; i++)
      begin : g_bit
         if (IMPL[i])
         begin : g_cell
            ues_flag_cell u_cell (
               .clk_in(clk_in),
               .arst_n_in(arst_n_in),
               .clear_in(clear_all),
               .event_in(ev_vec[i]),
               .w1c_in(w1c_vec[i]),
               .mask_we_in(mask_we_vec[i]),
               .mask_wd_in(cfg_wdata_in[i]),
               .flag_out(flags_vec[i]),
               .suppress_out(suppress_vec[i])
            );
         end
         else
         begin : g_rsvd
            assign flags_vec[i] = 1'b0;
            assign suppress_vec[i] = 1'b0;
         end
      end
   endgenerate

   // Errors that get past their suppress bit this cycle
   assign unmasked = clear_all ? 32'h0000_0000 :
                     (ev_vec & ~suppress_vec & IMPL);

   // Core next state: reset filter, read data, reporting
   always_comb
   begin
      next_s = s;

      // Three-stage pin capture; first stage feeds only the second
      next_s.sync_a = {link_reset_n_in, global_reset_input_n_in};
      next_s.sync_b = s.sync_a;
      next_s.sync_c = s.sync_b;
      // A level change counts once the last two stages agree
      for (int r = 0; r < 2; r++)
      begin
         if (s.sync_b[r] == s.sync_c[r])
         begin
            next_s.rst_lvl[r] = ~s.sync_c[r];
         end
      end

      // Read data is captured on the strobe and held until the next
      next_s.rvalid = cfg_rd_in;
      if (cfg_rd_in)
      begin
         case (sel)
            UES_SEL_FLAGS:
            begin
               next_s.rdata = flags_vec & IMPL;
            end
            UES_SEL_SUPPRESS:
            begin
               next_s.rdata = suppress_vec & IMPL;
            end
            default:
            begin
               next_s.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Each severity present among the new errors raises its own message
      next_s.msg_fatal = |(unmasked & severity_in);
      next_s.msg_nonfatal = |(unmasked & ~severity_in);

      // Header log loads only for errors that were let through
      next_s.log_load = |unmasked;
      next_s.log_vec = unmasked;

      // Pointer moves only when nothing was already pending
      next_s.first_upd = (|unmasked) && (flags_vec == 32'h0000_0000);
      if (next_s.first_upd)
      begin
         next_s.first_idx = ues_top_index(unmasked);
      end

      // Filtered reset also clears the reporting state
      if (clear_all)
      begin
         next_s.first_idx = 5'h00;
         next_s.log_vec = 32'h0000_0000;
      end
   end

   // Power-on reset leaves both reset levels asserted until pins settle
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         s.sync_a <= 2'b00;
         s.sync_b <= 2'b00;
         s.sync_c <= 2'b00;
         s.rst_lvl <= 2'b11;
         s.rdata <= 32'h0000_0000;
         s.rvalid <= 1'b0;
         s.msg_fatal <= 1'b0;
         s.msg_nonfatal <= 1'b0;
         s.log_load <= 1'b0;
         s.log_vec <= 32'h0000_0000;
         s.first_upd <= 1'b0;
         s.first_idx <= 5'h00;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs straight from flip-flops
   assign cfg_rdata_out = s.rdata;
   assign cfg_rvalid_out = s.rvalid;
   assign msg_fatal_out = s.msg_fatal;
   assign msg_nonfatal_out = s.msg_nonfatal;
   assign log_load_out = s.log_load;
   assign log_vec_out = s.log_vec;
   assign first_error_update_out = s.first_upd;
   assign first_error_index_out = s.first_idx;
   assign flags_out = flags_vec;
   assign suppress_out = suppress_vec;

endmodule
`default_nettype wire

// ===== sim/ues_regs_props.sv
// Checker for the uncorrectable error flag and suppress pair
`timescale 1ns/100ps
`default_nettype none
`include "ues_defs.svh"
module ues_regs_props
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic link_reset_n_in,
   input wire logic global_reset_input_n_in,
   input wire logic cfg_wr_in,
   input wire logic cfg_rd_in,
   input wire logic [11:0] cfg_addr_in,
   input wire logic [3:0] cfg_be_in,
   input wire logic [31:0] cfg_wdata_in,
   input wire logic [31:0] cfg_rdata_out,
   input wire logic cfg_rvalid_out,
   input wire logic unsupported_request_in,
   input wire logic end_to_end_crc_in,
   input wire logic malformed_packet_in,
   input wire logic receiver_overflow_in,
   input wire logic unexpected_completion_in,
   input wire logic completer_abort_in,
   input wire logic completion_timeout_in,
   input wire logic flow_control_protocol_in,
   input wire logic poisoned_packet_in,
   input wire logic link_protocol_in,
   input wire logic [31:0] severity_in,
   input wire logic msg_fatal_out,
   input wire logic msg_nonfatal_out,
   input wire logic log_load_out,
   input wire logic [31:0] flags_out,
   input wire logic [31:0] suppress_out
);
   localparam logic [11:0] AF = `UES_OFS_FLAGS;
   logic [31:0] ev;
   logic [31:0] un;
   logic [31:0] mk;
   logic [2:0] quiet;
   logic ok;
   logic fa;
   // Error inputs placed at their register positions
   assign ev = {11'h0, unsupported_request_in, end_to_end_crc_in,
      malformed_packet_in, receiver_overflow_in, unexpected_completion_in,
      completer_abort_in, completion_timeout_in, flow_control_protocol_in,
      poisoned_packet_in, 7'h0, link_protocol_in, 4'h0};
   assign un = ev & ~suppress_out;
   assign mk = ev & suppress_out & ~flags_out;
   assign ok = quiet == 3'h7;
   assign fa = cfg_addr_in[11:2] == AF[11:2];
   // Filtered resets lag the pins, so wait seven quiet edges
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in)
         quiet <= 3'h0;
      else if (!link_reset_n_in || !global_reset_input_n_in)
         quiet <= 3'h0;
      else if (!ok)
         quiet <= quiet + 3'h1;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   AST_SET:
   assert property (ok && |un |=> (flags_out & $past(un)) == $past(un))
      else $error("unsuppressed error left its flag clear");
   AST_SUPPRESSED:
   assert property (ok && |mk && !cfg_wr_in |=> !(|(flags_out & $past(mk))))
      else $error("suppressed error set its flag");
   AST_QUIET:
   assert property (ok && !(|un) |=> !msg_fatal_out && !msg_nonfatal_out
      && !log_load_out) else $error("report without unsuppressed error");
   AST_FATAL:
   assert property (ok && |(un & severity_in) |=> msg_fatal_out)
      else $error("fatal message missing");
   AST_NONFATAL:
   assert property (ok && |(un & ~severity_in) |=> msg_nonfatal_out)
      else $error("nonfatal message missing");
   AST_RSVD:
   assert property (((flags_out | suppress_out) & ~`UES_IMPL_MASK) == 32'h0)
      else $error("reserved bit set");
   AST_STICKY:
   assert property (ok && !cfg_wr_in |=>
      (flags_out & $past(flags_out)) == $past(flags_out))
      else $error("flag dropped without a write");
   AST_CLEAR:
   assert property (ok && cfg_wr_in && fa && cfg_be_in == 4'hf && !(|ev) |=>
      flags_out == ($past(flags_out) & ~$past(cfg_wdata_in)))
      else $error("write one clear wrong");
   AST_RVALID:
   assert property (cfg_rvalid_out == $past(cfg_rd_in))
      else $error("read valid timing wrong");
   AST_RDATA:
   assert property (cfg_rd_in && fa |=> cfg_rdata_out == $past(flags_out))
      else $error("flag read data wrong");
   AST_RESET:
   assert property ((!link_reset_n_in || !global_reset_input_n_in) [*6] |->
      flags_out == 32'h0 && suppress_out == 32'h0)
      else $error("reset pin left state");
   cover property (ok && |un && |(suppress_out & ev));
   cover property (ok && cfg_wr_in && fa && |(un & cfg_wdata_in));
   cover property (!global_reset_input_n_in [*6]);
endmodule
`default_nettype wire

// ===== sim/ues_link_model.sv
// Link layer stand-in raising error event pulses
`timescale 1ns/100ps
`default_nettype none
module ues_link_model
(
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic [9:0] req_in,
   output logic [9:0] ev_out
);
   // One pulse per request cycle; a held request repeats each cycle
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in)
         ev_out <= 10'h0;
      else
         ev_out <= req_in;
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the uncorrectable error register pair
`timescale 1ns/100ps
`default_nettype none
`include "ues_defs.svh"
module tb;
   logic clk_in, arst_n_in, lnk_n, glb_n, wr, rd, rv, mf, mn, ll, fu;
   logic [3:0] be;
   logic [4:0] fi;
   logic [9:0] req, ev;
   logic [11:0] ad;
   logic [11:0] at [3] = '{12'h104, 12'h108, 12'h10c};
   logic [31:0] wd, rdat, sev, lv, fl, su, xf, xs;
   int n_fail, n_compared;
   ues_link_model u_ues_link_model (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .req_in(req), .ev_out(ev));
   ues_regs u_ues_regs (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .link_reset_n_in(lnk_n), .global_reset_input_n_in(glb_n),
      .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_addr_in(ad), .cfg_be_in(be),
      .cfg_wdata_in(wd), .cfg_rdata_out(rdat), .cfg_rvalid_out(rv),
      .unsupported_request_in(ev[9]), .end_to_end_crc_in(ev[8]),
      .malformed_packet_in(ev[7]), .receiver_overflow_in(ev[6]),
      .unexpected_completion_in(ev[5]), .completer_abort_in(ev[4]),
      .completion_timeout_in(ev[3]), .flow_control_protocol_in(ev[2]),
      .poisoned_packet_in(ev[1]), .link_protocol_in(ev[0]),
      .severity_in(sev), .msg_fatal_out(mf), .msg_nonfatal_out(mn),
      .log_load_out(ll), .log_vec_out(lv), .first_error_update_out(fu),
      .first_error_index_out(fi), .flags_out(fl), .suppress_out(su));
   // Event vector to register positions
   function automatic logic [31:0] pm(input logic [9:0] v);
      pm = {11'h0, v[9:1], 7'h0, v[0], 4'h0};
   endfunction
   function automatic logic [4:0] hi(input logic [31:0] x);
      hi = 5'h0;
      for (int i = 0; i < 32; i++)
         if (x[i])
            hi = i[4:0];
   endfunction
   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Event request, then access taken on the same edge as the event
   task automatic step(input logic [9:0] v, input logic w, r,
      input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
      logic [31:0] un, bm, old;
      un = pm(v) & ~xs;
      bm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & `UES_IMPL_MASK;
      old = a[11:2] == 10'h041 ? xf : a[11:2] == 10'h042 ? xs : 32'h0;
      @(posedge clk_in);
      req <= v;
      @(posedge clk_in);
      req <= 10'h0;
      wr <= w;
      rd <= r;
      ad <= a;
      be <= b;
      wd <= d;
      @(posedge clk_in);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      chk("fatal", mf, |(un & sev));
      chk("nonfatal", mn, |(un & ~sev));
      chk("log", ll, |un);
      chk("logvec", lv, un);
      chk("first", fu, |un && xf == 32'h0);
      if (fu === 1'b1)
         chk("index", fi, hi(un));
      if (w && a[11:2] == 10'h041)
         xf = xf & ~(d & bm);
      if (w && a[11:2] == 10'h042)
         xs = (xs & ~bm) | (d & bm);
      xf = xf | un;
      chk("set a", fl[20:16], xf[20:16]);
      chk("set b", {fl[15:12], fl[4]}, {xf[15:12], xf[4]});
      chk("flags", fl, xf);
      chk("suppress", su, xs);
      chk("rvalid", rv, r);
      if (r)
         chk("rdata", rdat, old);
   endtask
   initial
   begin
      clk_in = 1'b0;
      forever
         #4 clk_in = ~clk_in;
   end
   // Watchdog against a hang
   initial
   begin
      #400000;
      n_fail++;
      conclude();
   end
   initial
   begin
      {arst_n_in, wr, rd, ad, be, wd, req, sev, xf, xs} = '0;
      {lnk_n, glb_n} = 2'b11;
      n_fail = 0;
      n_compared = 0;
      void'($urandom(82));
      repeat (12) @(posedge clk_in);
      arst_n_in <= 1'b1;
      sev <= $urandom;
      repeat (6) @(posedge clk_in);
      step(10'h0, 1'b0, 1'b1, `UES_OFS_FLAGS, 4'h0, 32'h0);
      step(10'h0, 1'b0, 1'b1, `UES_OFS_SUPPRESS, 4'h0, 32'h0);
      step(10'h0, 1'b1, 1'b1, 12'h10c, 4'hf, 32'hffff_ffff);
      $display("reset values done");
      // Each error alone, a zero write that keeps it, then its clear
      for (int i = 0; i < 10; i++)
      begin
         step(10'h1 << i, 1'b0, 1'b0, 12'h0, 4'h0, 32'h0);
         step(10'h0, 1'b1, 1'b0, `UES_OFS_FLAGS, 4'hf, ~pm(10'h1 << i));
         step(10'h0, 1'b1, 1'b1, `UES_OFS_FLAGS, 4'hf, pm(10'h1 << i));
      end
      $display("single errors done");
      step(10'h0, 1'b1, 1'b1, `UES_OFS_SUPPRESS, 4'hf, 32'hffff_ffff);
      step(10'h3ff, 1'b0, 1'b1, `UES_OFS_SUPPRESS, 4'h0, 32'h0);
      step(10'h0, 1'b1, 1'b0, `UES_OFS_SUPPRESS, 4'hf, 32'h0);
      step(10'h3ff, 1'b0, 1'b0, 12'h0, 4'h0, 32'h0);
      step(10'h3ff, 1'b1, 1'b1, `UES_OFS_FLAGS, 4'hf, 32'hffff_ffff);
      $display("suppress and priority done");
      // Random traffic with byte enables and all three addresses
      for (int i = 0; i < 80; i++)
      begin
         @(posedge clk_in);
         sev <= $urandom;
         step(10'($urandom), 1'($urandom), 1'($urandom),
            at[$urandom_range(0, 2)], 4'($urandom), $urandom);
      end
      $display("random traffic done");
      // Each reset pin clears both registers
      for (int k = 0; k < 2; k++)
      begin
         step(10'h3ff, 1'b1, 1'b0, `UES_OFS_SUPPRESS, 4'hf, 32'h0000_f000);
         @(posedge clk_in);
         lnk_n <= k[0];
         glb_n <= !k[0];
         repeat (6) @(posedge clk_in);
         #1;
         chk("flags", fl, 32'h0);
         chk("suppress", su, 32'h0);
         @(posedge clk_in);
         {lnk_n, glb_n} <= 2'b11;
         repeat (6) @(posedge clk_in);
         xf = 32'h0;
         xs = 32'h0;
      end
      $display("reset pins done");
      conclude();
   end
endmodule
bind ues_regs ues_regs_props u_ues_regs_props (.*);
`default_nettype wire
